//--- core/status_lamp_pkg.sv
package status_lamp_pkg;

   // Clock rate and blink timing.
   localparam int unsigned ClockHz = 10_000_000;
   localparam int unsigned SlowBlinkHz = 1;
   localparam int unsigned FastBlinkHz = 4;
   // Half periods in cycles (fifty percent duty cycle).
   localparam int unsigned SlowHalfCycles = ClockHz / (2 * SlowBlinkHz);
   localparam int unsigned FastHalfCycles = ClockHz / (2 * FastBlinkHz);

   // APB register byte offsets.
   localparam logic [7:0] CondOffset = 8'h00;
   localparam logic [7:0] LampOffset = 8'h04;
   localparam logic [7:0] StateOffset = 8'h08;

   // Condition register field positions.
   localparam int unsigned CondSelfTest = 0;
   localparam int unsigned CondMajor = 1;
   localparam int unsigned CondMinor = 2;
   localparam int unsigned CondUnconfigured = 3;
   localparam int unsigned CondOperational = 4;
   localparam int unsigned CondHasAddress = 5;
   localparam int unsigned CondConnected = 6;
   localparam int unsigned CondDuplicate = 7;
   localparam int unsigned CondWidth = 8;
   localparam logic [CondWidth-1:0] CondReset = 8'h01;

   // Decoded indicator states.
   typedef enum logic [2:0] {
      ModOff, ModSelfTest, ModMajor, ModMinor, ModNoAddr, ModStandby, ModRun
   } mod_state_t;

   typedef enum logic [2:0] {
      NetOff, NetSelfTest, NetDuplicate, NetTimeout, NetConnected, NetIdle
   } net_state_t;

endpackage : status_lamp_pkg

//--- core/blink_if.sv
`timescale 1ns/100ps
interface blink_if;
   logic slow;
   logic fast;
   modport source (output slow, output fast);
   modport sink (input slow, input fast);
endinterface : blink_if

//--- core/blink_gen.sv
`timescale 1ns/100ps
module blink_gen
   import status_lamp_pkg::*;
#(
   parameter int unsigned SlowHalf = SlowHalfCycles,
   parameter int unsigned FastHalf = FastHalfCycles
) (
   // System.
   input wire logic clk,
   input wire logic rst,
   // Blink phases.
   blink_if.source blink
);

   typedef struct packed {
      logic [31:0] slowCount;
      logic [31:0] fastCount;
      logic slow;
      logic fast;
   } gen_state_t;

   gen_state_t state;
   gen_state_t next_state;

   // Two free-running half-period counters toggle the phases.
   always_comb begin
      next_state = state;
      if (state.slowCount >= 32'(SlowHalf - 1)) begin
         next_state.slowCount = '0;
         next_state.slow = ~state.slow;
      end else begin
         next_state.slowCount = state.slowCount + 32'h0000_0001;
      end
      if (state.fastCount >= 32'(FastHalf - 1)) begin
         next_state.fastCount = '0;
         next_state.fast = ~state.fast;
      end else begin
         next_state.fastCount = state.fastCount + 32'h0000_0001;
      end
   end

   // Counters restart at reset so every blink starts in its lit phase.
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '{slowCount: '0, fastCount: '0, slow: 1'b1, fast: 1'b1};
      end else begin
         state <= next_state;
      end
   end

   assign blink.slow = state.slow;
   assign blink.fast = state.fast;

endmodule : blink_gen

//--- core/status_indicator_driver.sv
`timescale 1ns/100ps
module status_indicator_driver
   import status_lamp_pkg::*;
#(
   parameter int unsigned SlowHalf = SlowHalfCycles,
   parameter int unsigned FastHalf = FastHalfCycles
) (
   // System.
   input wire logic clk,
   input wire logic rst,
   // Connection timeout events from the network stack.
   input wire logic timeoutEvent,
   input wire logic timedOutOpen,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Module status lamps.
   output logic module_green_lamp,
   output logic module_red_lamp,
   // Network status lamps for both ports.
   output logic port_a_network_lamp,
   output logic port_a_activity_lamp,
   output logic port_b_network_lamp,
   output logic port_b_activity_lamp
);

   typedef struct packed {
      logic [CondWidth-1:0] cond;
      logic timeoutLatch;
      mod_state_t modState;
      net_state_t netState;
      logic modGreen;
      logic modRed;
      logic netGreen;
      logic netYellow;
      logic [31:0] rdata;
   } drv_state_t;

   drv_state_t state;
   drv_state_t next_state;

   blink_if blink ();

   ////////////////////////////////////////////////////////////////////////
   // Blink phase source.

   // Both blink rates come from counting system clock cycles, nothing else.
   blink_gen #(
      .SlowHalf(SlowHalf),
      .FastHalf(FastHalf)
   ) u_blink (
      .clk(clk),
      .rst(rst),
      .blink(blink)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic access;
   logic mapped;
   assign access = psel & penable;
   assign mapped = (paddr == CondOffset) || (paddr == LampOffset) || (paddr == StateOffset);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      next_state = state;

      // Software condition register write.
      if (access && pwrite && paddr == CondOffset) begin
         next_state.cond = pwdata[CondWidth-1:0];
      end

      // A new timeout wins over the clear so an event is never lost.
      if (timeoutEvent) begin
         next_state.timeoutLatch = 1'b1;
      end else if (!timedOutOpen) begin
         next_state.timeoutLatch = 1'b0;
      end

      // Module indicator priority.
      if (state.cond[CondSelfTest]) begin
         next_state.modState = ModSelfTest;
      end else if (state.cond[CondMajor]) begin
         next_state.modState = ModMajor;
      end else if (state.cond[CondMinor]) begin
         next_state.modState = ModMinor;
      end else if (!state.cond[CondHasAddress]) begin
         next_state.modState = ModNoAddr;
      end else if (state.cond[CondUnconfigured]) begin
         next_state.modState = ModStandby;
      end else if (state.cond[CondOperational]) begin
         next_state.modState = ModRun;
      end else begin
         next_state.modState = ModOff;
      end

      // Network indicator priority.
      if (state.cond[CondSelfTest]) begin
         next_state.netState = NetSelfTest;
      end else if (state.cond[CondDuplicate]) begin
         next_state.netState = NetDuplicate;
      end else if (!state.cond[CondHasAddress]) begin
         next_state.netState = NetOff;
      end else if (state.timeoutLatch) begin
         next_state.netState = NetTimeout;
      end else if (state.cond[CondConnected]) begin
         next_state.netState = NetConnected;
      end else begin
         next_state.netState = NetIdle;
      end

      // Module lamp drive.
      unique case (state.modState)
         ModSelfTest: begin
            next_state.modGreen = blink.slow;
            next_state.modRed = ~blink.slow;
         end
         ModMajor: begin
            next_state.modGreen = 1'b0;
            next_state.modRed = 1'b1;
         end
         ModMinor: begin
            next_state.modGreen = 1'b0;
            next_state.modRed = blink.slow;
         end
         ModNoAddr: begin
            next_state.modGreen = blink.fast;
            next_state.modRed = 1'b0;
         end
         ModStandby: begin
            next_state.modGreen = blink.slow;
            next_state.modRed = 1'b0;
         end
         ModRun: begin
            next_state.modGreen = 1'b1;
            next_state.modRed = 1'b0;
         end
         ModOff: begin
            next_state.modGreen = 1'b0;
            next_state.modRed = 1'b0;
         end
      endcase

      // Network lamp drive; yellow is the activity lamp.
      unique case (state.netState)
         NetSelfTest: begin
            next_state.netGreen = blink.slow;
            next_state.netYellow = ~blink.slow;
         end
         NetDuplicate: begin
            next_state.netGreen = 1'b0;
            next_state.netYellow = 1'b1;
         end
         NetTimeout: begin
            next_state.netGreen = 1'b0;
            next_state.netYellow = blink.slow;
         end
         NetConnected: begin
            next_state.netGreen = 1'b1;
            next_state.netYellow = 1'b0;
         end
         NetIdle: begin
            next_state.netGreen = blink.slow;
            next_state.netYellow = 1'b0;
         end
         NetOff: begin
            next_state.netGreen = 1'b0;
            next_state.netYellow = 1'b0;
         end
      endcase

      // Read data is registered during the setup cycle.
      next_state.rdata = '0;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            CondOffset: next_state.rdata = {24'h00_0000, state.cond};
            LampOffset: next_state.rdata = {26'h000_0000, state.timeoutLatch,
               1'b0, state.netYellow, state.netGreen, state.modRed, state.modGreen};
            StateOffset: next_state.rdata = {25'h000_0000, state.netState,
               1'b0, state.modState};
            default: next_state.rdata = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset starts in self-test with all lamps dark.

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '{cond: CondReset, timeoutLatch: 1'b0, modState: ModOff,
            netState: NetOff, modGreen: 1'b0, modRed: 1'b0, netGreen: 1'b0,
            netYellow: 1'b0, rdata: '0};
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs. Both ports show the same device-level network state.

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = state.rdata;
   assign module_green_lamp = state.modGreen;
   assign module_red_lamp = state.modRed;
   assign port_a_network_lamp = state.netGreen;
   assign port_b_network_lamp = state.netGreen;
   assign port_a_activity_lamp = state.netYellow;
   assign port_b_activity_lamp = state.netYellow;

endmodule : status_indicator_driver

//--- testbench/status_indicator_driver_props.sv
`timescale 1ns/100ps
module status_indicator_driver_props
   import status_lamp_pkg::*;
#(
   parameter int unsigned SlowHalf = SlowHalfCycles,
   parameter int unsigned FastHalf = FastHalfCycles
) (
   // System.
   input wire logic clk,
   input wire logic rst,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // Lamps.
   input wire logic module_green_lamp,
   input wire logic module_red_lamp,
   input wire logic port_a_network_lamp,
   input wire logic port_a_activity_lamp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] cond;
   logic prevGreen;
   int unsigned run;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the condition register, so lamp checks know what software asked for.
   always_ff @(posedge clk) begin
      if (rst) begin
         cond <= CondReset;
      end else if (psel && penable && pwrite && paddr == CondOffset) begin
         cond <= pwdata[7:0];
      end
   end
   // Length of an unchanged green run while no address is held; a slow blink overruns it.
   always_ff @(posedge clk) begin
      prevGreen <= module_green_lamp;
      if (rst || (cond & 8'h27) != 8'h00 || module_green_lamp != prevGreen) begin
         run <= 0;
      end else begin
         run <= run + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Conditions are held five cycles so the two-cycle lamp latency has passed.
   selftest_mod_a: assert property (cond[0] [*5] |-> module_red_lamp != module_green_lamp)
      else $error("Module lamps do not alternate in self-test.");
   selftest_net_a: assert property (
      cond[0] [*5] |-> port_a_activity_lamp != port_a_network_lamp)
      else $error("Network lamps do not alternate in self-test.");
   major_red_a: assert property (
      ((cond & 8'h03) == 8'h02) [*5] |-> module_red_lamp)
      else $error("Red lamp not steady on major fault.");
   run_green_a: assert property (
      ((cond & 8'h3F) == 8'h30) [*5] |-> module_green_lamp && !module_red_lamp)
      else $error("Green lamp not steady while operational.");
   minor_green_a: assert property (
      ((cond & 8'h07) == 8'h04) [*5] |-> !module_green_lamp)
      else $error("Green lamp lit during minor fault.");
   noaddr_dark_a: assert property (
      ((cond & 8'hA1) == 8'h00) [*5] |-> !port_a_network_lamp && !port_a_activity_lamp)
      else $error("Network lamps lit without address.");
   duplicate_a: assert property (
      ((cond & 8'h81) == 8'h80) [*5] |-> port_a_activity_lamp && !port_a_network_lamp)
      else $error("Yellow lamp not steady on duplicate address.");
   fast_blink_a: assert property (run < FastHalf + 4)
      else $error("Green lamp blinks too slowly without address.");
endmodule : status_indicator_driver_props
bind status_indicator_driver status_indicator_driver_props #(
   .SlowHalf(SlowHalf),
   .FastHalf(FastHalf)
) i_props (.*);

//--- testbench/cond_source.sv
`timescale 1ns/100ps
module cond_source (
   // System.
   input wire logic clk,
   // Requests from the bench.
   input wire logic raise,
   input wire logic restore,
   // Flags toward the driver.
   output logic timeoutEvent = 1'b0,
   output logic timedOutOpen = 1'b0
);
   // A timeout arrives as a one-cycle event; the connection stays open until restored.
   always @(posedge clk) begin
      timeoutEvent <= raise;
      timedOutOpen <= raise | (timedOutOpen & ~restore);
   end
endmodule : cond_source

//--- testbench/status_indicator_driver_test.sv
`timescale 1ns/100ps
module status_indicator_driver_test;
   import status_lamp_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic raise = 1'b0, restore = 1'b0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic green, red, aNet, aAct, bNet, bAct, timeoutEvent, timedOutOpen;
   wire [3:0] lamps = {aAct, aNet, red, green};
   int n_errors = 0, compares = 0;
   // Short blink counts keep the run brief; expectations follow from them.
   always #50 clk = ~clk;
   status_indicator_driver #(.SlowHalf(8), .FastHalf(2)) i_dut (.clk(clk), .rst(rst),
      .timeoutEvent(timeoutEvent), .timedOutOpen(timedOutOpen), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .module_green_lamp(green), .module_red_lamp(red),
      .port_a_network_lamp(aNet), .port_a_activity_lamp(aAct), .port_b_network_lamp(bNet),
      .port_b_activity_lamp(bAct));
   cond_source i_src (.clk(clk), .raise(raise), .restore(restore),
      .timeoutEvent(timeoutEvent), .timedOutOpen(timedOutOpen));
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // The answer is taken at the rising edge that sees pready high, before that edge's updates land.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         finish_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Codes per lamp: 0 off, 1 steady on, 2 slow blink, 8 fast blink (rises in 32 cycles).
   task run_case(input logic [7:0] c, input int g, input int r, input int n, input int y);
      logic [3:0] prev;
      int rises[4];
      int ex[4];
      ex = '{g, r, n, y};
      rises = '{default: 0};
      apb(1'b1, CondOffset, {24'h0000_00, c});
      repeat (4) @(negedge clk);
      prev = lamps;
      repeat (32) begin
         @(negedge clk);
         for (int k = 0; k < 4; k++) begin
            if (lamps[k] && !prev[k]) begin
               rises[k]++;
            end
         end
         prev = lamps;
      end
      for (int k = 0; k < 4; k++) begin
         check($sformatf("lamp %0d rises", k), rises[k], ex[k] > 1 ? ex[k] : 0);
         if (ex[k] < 2) begin
            check($sformatf("lamp %0d level", k), lamps[k], ex[k]);
         end
      end
      check("port b mirror", {bNet, bAct}, {aNet, aAct});
   endtask : run_case
   task pulse(input logic which);
      @(posedge clk);
      if (which) raise <= 1'b1;
      else restore <= 1'b1;
      @(posedge clk);
      raise <= 1'b0;
      restore <= 1'b0;
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, CondOffset, 32'h0000_0000);
      check("cond reset", q, 32'h0000_0001);
      run_case(8'h70, 1, 0, 1, 0);
      apb(1'b0, LampOffset, 32'h0000_0000);
      check("lamp register", q, 32'h0000_0005);
      apb(1'b0, StateOffset, 32'h0000_0000);
      check("state register", q, {25'h000_0000, NetConnected, 1'b0, ModRun});
      run_case(8'h30, 1, 0, 2, 0);
      run_case(8'h10, 8, 0, 0, 0);
      run_case(8'h28, 2, 0, 2, 0);
      run_case(8'h18, 8, 0, 0, 0);
      run_case(8'h74, 0, 2, 1, 0);
      run_case(8'h76, 0, 1, 1, 0);
      run_case(8'hF4, 0, 2, 0, 1);
      run_case(8'hFF, 2, 2, 2, 2);
      $display("Test lamp states done");
      run_case(8'h70, 1, 0, 1, 0);
      pulse(1'b1);
      run_case(8'h70, 1, 0, 0, 2);
      run_case(8'h70, 1, 0, 0, 2);
      apb(1'b0, LampOffset, 32'h0000_0000);
      check("timeout latch bit", q & 32'h0000_0023, 32'h0000_0021);
      pulse(1'b0);
      run_case(8'h70, 1, 0, 1, 0);
      pulse(1'b1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      run_case(8'h70, 1, 0, 1, 0);
      pulse(1'b0);
      $display("Test timeout latch done");
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      check("unmapped write error", e, 1);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check("unmapped error", e, 1);
      check("unmapped data", q, 32'h0000_0000);
      apb(1'b0, CondOffset, 32'h0000_0000);
      check("cond kept", q, 32'h0000_0070);
      $display("Test unmapped access done");
      finish_test();
   end
endmodule : status_indicator_driver_test
